/* File: logic/mal_pkg.sv */
/*
  Shared constants and types for the monitor auxiliary pin logic.
  Assumes a single 40 MHz core clock and a register port fed by the
  serial bus engine, which decodes frames into byte-wide accesses.
*/
package mal_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 40_000_000;
  localparam int unsigned PULSE_MS     = 20;     // Least pulse width
  // Least time in whole cycles, never less than one
  localparam int unsigned PULSE_CYCLES =
    (PULSE_MS * (CLK_HZ / 1000) + 0) > 0 ?
    (PULSE_MS * (CLK_HZ / 1000)) : 1;
  localparam int unsigned CNT_W        = 20;     // Holds PULSE_CYCLES

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_CHAN_MODE  = 8'h16;
  localparam logic [7:0] OFF_CONFIG     = 8'h40;
  localparam logic [7:0] OFF_STATUS     = 8'h41;
  localparam logic [7:0] OFF_INTR_CLEAR = 8'h46;
  localparam logic [7:0] OFF_VID_FAN    = 8'h47;
  localparam logic [7:0] OFF_VID_HIGH   = 8'h49;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CFG_INT_EN    = 1;
  localparam int unsigned CFG_RST_EN    = 4;
  localparam int unsigned CHM_VID_IRQ   = 0;
  localparam int unsigned CHM_DIODE2    = 1;
  localparam int unsigned CHM_ALERT     = 2;
  localparam int unsigned CLR_GO        = 7;
  localparam int unsigned ST_INTRUSION  = 0;
  localparam int unsigned ST_ALERT      = 1;
  localparam int unsigned ST_TREE       = 2;
  localparam int unsigned VID_LOW_W     = 4;
  localparam int unsigned VID_W         = 5;
  localparam logic [7:0]  REG_RST       = 8'h00;
  localparam logic [7:0]  RD_UNMAPPED   = 8'h00;

  // Register access from the serial bus engine
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } mal_reg_req_t;

endpackage

/* File: logic/mal_pulse_timer.sv */
/*
  Retriggerable-free pulse timer: a start while idle opens a pulse of
  exactly LEN enabled cycles. Assumes start is a level sampled with
  clk_en; a start during a running pulse is ignored.
*/
`timescale 1ns/1ps
module mal_pulse_timer
  import mal_pkg::*;
#(
  parameter int unsigned LEN = PULSE_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic sys_rst,
  input  wire logic clk_en,
  input  wire logic start,
  output logic      active
);

  logic [CNT_W-1:0] count;
  logic [CNT_W-1:0] next_count;
  logic             next_active;

  // ------------------------------------------------------------------
  // Countdown
  // ------------------------------------------------------------------
  // Count down from LEN-1 so the pulse spans LEN cycles exactly
  always_comb begin
    next_count  = count;
    next_active = active;
    if (!active && start) begin
      next_active = 1'b1;
      next_count  = CNT_W'(LEN - 1);
    end else if (active) begin
      if (count == '0) begin
        next_active = 1'b0;
      end else begin
        next_count = count - 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      active <= 1'b0;
      count  <= '0;
    end else if (clk_en) begin
      active <= next_active;
      count  <= next_count;
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  // Helper: cycles the pulse has stood so far
  logic [CNT_W-1:0] run_len;
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      run_len <= '0;
    end else if (clk_en) begin
      run_len <= active ? run_len + 1'b1 : '0;
    end
  end

  property p_pulse_len;
    @(posedge core_clk) disable iff (sys_rst)
      $fell(active) |-> (run_len == CNT_W'(LEN));
  endproperty
  a_pulse_len: assert property (p_pulse_len) // RQ6
    else $error("pulse ended before its least width");

endmodule

/* File: logic/mal_aux_pins.sv */
/*
  Auxiliary pin logic of the hardware monitor: intrusion latch with a
  timed clear pulse, interrupt/alert output, master reset pulse and
  reset input, tree test entry at power-up, and the dual-use input
  and diode mode selects. Assumes the serial bus engine delivers
  byte-wide accesses on reg_req and that all pins are synchronous.
*/
// What this block does
// (RQ1) A high intrusion pin is latched and kept after it drops.
// (RQ2) Writing bit 7 of intrusion_clear pulls the pin low >= 20 ms.
// (RQ3) Interrupt pin is driven only while configuration bit 1 is set.
// (RQ4) After reset the interrupt enable is clear and the pin released.
// (RQ5) Interrupt pin may act as an alert output for alert response.
// (RQ6) Master reset output is pulled low for at least 20 ms.
// (RQ7) Master reset pulse happens only when configuration bit 4 is set.
// (RQ8) Reset pin driven low by others resets the device.
// (RQ9) Converter pin high at power-up enters the tree test mode.
// (RQ10) Voltage-ID pins serve as voltage-ID or interrupt inputs.
// (RQ11) Sampled voltage-ID levels are readable in two registers.
// (RQ12) Register selects second core/2.5 V sensing or second diode.
// (RQ13) Intrusion latch holds until the clear pulse removes it.
`timescale 1ns/1ps
module mal_aux_pins
  import mal_pkg::*;
#(
  parameter int unsigned PULSE_LEN = PULSE_CYCLES
) (
  input  wire logic               core_clk,
  input  wire logic               sys_rst,
  input  wire logic               clk_en,
  input  wire mal_reg_req_t       reg_req,
  output logic [7:0]              reg_rdata,
  output logic                    reg_rvalid,
  input  wire logic               intrusion_pin_in,
  output logic                    intrusion_pin_oe_n,
  input  wire logic               int_req,
  input  wire logic               alert_ack,
  output logic                    int_pin_oe_n,
  input  wire logic               reset_trigger,
  input  wire logic               reset_pin_in,
  output logic                    reset_pin_oe_n,
  output logic                    ext_reset_seen,
  input  wire logic               dac_out_test_in,
  output logic                    tree_test_entry,
  input  wire logic [VID_W-1:0]   voltage_id_inputs,
  output logic                    ext_irq_active,
  output logic                    diode2_mode
);

  typedef enum logic [1:0] {
    MAL_RST_IDLE,
    MAL_RST_PULSE,
    MAL_RST_RELEASE
  } mal_rst_state_t;

  // Address decode shared by the write and read paths
  function automatic logic reg_hit(input logic [7:0] addr,
                                   input logic [7:0] off);
    reg_hit = (addr == off);
  endfunction

  logic dev_rst;
  assign dev_rst = sys_rst | ext_reset_seen;

  // ------------------------------------------------------------------
  // Writable registers
  // ------------------------------------------------------------------
  logic [7:0] cfg, chan_mode, clr_reg, fan_div;
  logic [7:0] next_cfg, next_chan_mode, next_clr_reg, next_fan_div;
  logic       clr_go;

  // Byte writes land in the addressed register; bit 7 of the clear
  // register is a command, not storage
  always_comb begin
    next_cfg       = cfg;
    next_chan_mode = chan_mode;
    next_clr_reg   = clr_reg;
    next_fan_div   = fan_div;
    clr_go         = 1'b0;
    if (reg_req.wr) begin
      if (reg_hit(reg_req.addr, OFF_CONFIG)) begin
        next_cfg = reg_req.wdata;
      end
      if (reg_hit(reg_req.addr, OFF_CHAN_MODE)) begin
        next_chan_mode = reg_req.wdata;                   // RQ12
      end
      if (reg_hit(reg_req.addr, OFF_INTR_CLEAR)) begin
        next_clr_reg           = reg_req.wdata;
        next_clr_reg[CLR_GO]   = 1'b0;
        clr_go                 = reg_req.wdata[CLR_GO];   // RQ2
      end
      if (reg_hit(reg_req.addr, OFF_VID_FAN)) begin
        next_fan_div = {reg_req.wdata[7:VID_LOW_W], 4'h0};
      end
    end
  end

  // Reset clears the interrupt enable with the rest of the register
  always_ff @(posedge core_clk) begin
    if (dev_rst) begin
      cfg       <= REG_RST;                               // RQ4
      chan_mode <= REG_RST;
      clr_reg   <= REG_RST;
      fan_div   <= REG_RST;
    end else if (clk_en) begin
      cfg       <= next_cfg;
      chan_mode <= next_chan_mode;
      clr_reg   <= next_clr_reg;
      fan_div   <= next_fan_div;
    end
  end

  // ------------------------------------------------------------------
  // Pulse timers
  // ------------------------------------------------------------------
  logic clr_active, rst_pulse_active, rst_start;

  mal_pulse_timer #(.LEN(PULSE_LEN)) u_clr_timer (
    .core_clk (core_clk),
    .sys_rst  (dev_rst),
    .clk_en   (clk_en),
    .start    (clr_go),
    .active   (clr_active)
  );

  mal_pulse_timer #(.LEN(PULSE_LEN)) u_rst_timer (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .clk_en   (clk_en),
    .start    (rst_start),
    .active   (rst_pulse_active)
  );

  // ------------------------------------------------------------------
  // Intrusion latch and inputs
  // ------------------------------------------------------------------
  logic             intr_latched, next_intr_latched;
  logic [VID_W-1:0] vid_q;
  logic             irq_any;

  // A high pin wins over a clear still in progress
  always_comb begin
    next_intr_latched = intr_latched;
    if (clr_active) begin
      next_intr_latched = 1'b0;                           // RQ13
    end
    if (intrusion_pin_in) begin
      next_intr_latched = 1'b1;                           // RQ1
    end
  end

  // Pins have pullups, so an interrupt request is a low level
  assign irq_any = chan_mode[CHM_VID_IRQ] & ~(&vid_q);   // RQ10

  always_ff @(posedge core_clk) begin
    if (dev_rst) begin
      intr_latched       <= 1'b0;
      intrusion_pin_oe_n <= 1'b1;
      vid_q              <= '0;
      ext_irq_active     <= 1'b0;
      diode2_mode        <= 1'b0;
    end else if (clk_en) begin
      intr_latched       <= next_intr_latched;
      intrusion_pin_oe_n <= ~clr_active;                  // RQ2
      vid_q              <= voltage_id_inputs;            // RQ11
      ext_irq_active     <= irq_any;
      diode2_mode        <= next_chan_mode[CHM_DIODE2];   // RQ12
    end
  end

  // ------------------------------------------------------------------
  // Interrupt and alert output
  // ------------------------------------------------------------------
  logic int_src, alert_pend, next_alert_pend, next_int_oe_n;

  // Alert stays pending until answered; a new event beats the answer
  always_comb begin
    int_src         = int_req | irq_any;
    next_alert_pend = alert_pend;
    if (alert_ack) begin
      next_alert_pend = 1'b0;                             // RQ5
    end
    if (int_src) begin
      next_alert_pend = 1'b1;
    end
    next_int_oe_n = ~(cfg[CFG_INT_EN] &                   // RQ3
      (chan_mode[CHM_ALERT] ? alert_pend : int_src));     // RQ5
  end

  always_ff @(posedge core_clk) begin
    if (dev_rst) begin
      alert_pend   <= 1'b0;
      int_pin_oe_n <= 1'b1;                               // RQ4
    end else if (clk_en) begin
      alert_pend   <= next_alert_pend;
      int_pin_oe_n <= next_int_oe_n;
    end
  end

  // ------------------------------------------------------------------
  // Master reset output and reset input
  // ------------------------------------------------------------------
  mal_rst_state_t rst_state, next_rst_state;
  logic           next_ext_reset;

  // While the pin is ours, or still rising after our pulse, its low
  // level is not an outside reset
  always_comb begin
    next_rst_state = rst_state;
    rst_start      = 1'b0;
    next_ext_reset = 1'b0;
    case (rst_state)
      MAL_RST_IDLE: begin
        next_ext_reset = ~reset_pin_in;                   // RQ8
        if (reset_trigger && cfg[CFG_RST_EN] && reset_pin_in) begin
          rst_start      = 1'b1;                          // RQ7
          next_rst_state = MAL_RST_PULSE;
        end
      end
      MAL_RST_PULSE: begin
        if (!rst_pulse_active) begin
          next_rst_state = MAL_RST_RELEASE;
        end
      end
      MAL_RST_RELEASE: begin
        if (reset_pin_in) begin
          next_rst_state = MAL_RST_IDLE;
        end
      end
      default: begin
        next_rst_state = MAL_RST_IDLE;
      end
    endcase
  end

  // Only the outer reset clears this group, so the pin reset cannot
  // cut its own pulse short
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      rst_state      <= MAL_RST_IDLE;
      reset_pin_oe_n <= 1'b1;
      ext_reset_seen <= 1'b0;
    end else if (clk_en) begin
      rst_state      <= next_rst_state;
      reset_pin_oe_n <= ~(rst_start | (rst_pulse_active &&
                          rst_state == MAL_RST_PULSE));   // RQ6
      ext_reset_seen <= next_ext_reset;
    end
  end

  // ------------------------------------------------------------------
  // Tree test entry and read-back
  // ------------------------------------------------------------------
  logic       tree_taken;
  logic [7:0] status, next_rdata;

  assign status = {5'h00, tree_test_entry, alert_pend, intr_latched};

  always_comb begin
    next_rdata = RD_UNMAPPED;
    if (reg_hit(reg_req.addr, OFF_CONFIG)) begin
      next_rdata = cfg;
    end else if (reg_hit(reg_req.addr, OFF_CHAN_MODE)) begin
      next_rdata = chan_mode;
    end else if (reg_hit(reg_req.addr, OFF_STATUS)) begin
      next_rdata = status;
    end else if (reg_hit(reg_req.addr, OFF_INTR_CLEAR)) begin
      next_rdata = {clr_active, clr_reg[6:0]};
    end else if (reg_hit(reg_req.addr, OFF_VID_FAN)) begin
      next_rdata = {fan_div[7:VID_LOW_W], vid_q[VID_LOW_W-1:0]}; // RQ11
    end else if (reg_hit(reg_req.addr, OFF_VID_HIGH)) begin
      next_rdata = {7'h00, vid_q[VID_W-1]};               // RQ11
    end
  end

  // The strap is taken once, on the first enabled cycle after reset
  always_ff @(posedge core_clk) begin
    if (dev_rst) begin
      tree_taken      <= 1'b0;
      tree_test_entry <= 1'b0;
      reg_rdata       <= RD_UNMAPPED;
      reg_rvalid      <= 1'b0;
    end else if (clk_en) begin
      tree_taken      <= 1'b1;
      if (!tree_taken) begin
        tree_test_entry <= dac_out_test_in;               // RQ9
      end
      reg_rvalid      <= reg_req.rd;
      if (reg_req.rd) begin
        reg_rdata     <= next_rdata;
      end
    end
  end

  // ------------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------------
  sequence s_clr_write;
    reg_req.wr && clk_en && reg_req.wdata[CLR_GO] &&
    reg_req.addr == OFF_INTR_CLEAR && !clr_active;
  endsequence

  property p_intr_set;
    @(posedge core_clk) disable iff (dev_rst)
      (intrusion_pin_in && clk_en) |=> intr_latched;
  endproperty
  a_intr_set: assert property (p_intr_set) // RQ1
    else $error("intrusion event not latched");

  property p_intr_hold;
    @(posedge core_clk) disable iff (dev_rst)
      (intr_latched && !clr_active) |=> intr_latched;
  endproperty
  a_intr_hold: assert property (p_intr_hold) // RQ13
    else $error("intrusion latch dropped without clear");

  property p_clr_drive;
    @(posedge core_clk) disable iff (dev_rst)
      s_clr_write ##1 clk_en |=> !intrusion_pin_oe_n;
  endproperty
  a_clr_drive: assert property (p_clr_drive) // RQ2
    else $error("clear write did not pull intrusion pin");

  property p_int_gate;
    @(posedge core_clk) disable iff (dev_rst)
      (!cfg[CFG_INT_EN] && clk_en) |=> int_pin_oe_n;
  endproperty
  a_int_gate: assert property (p_int_gate) // RQ3
    else $error("interrupt pin driven while disabled");

  property p_int_reset;
    @(posedge core_clk) dev_rst |=> (int_pin_oe_n && !cfg[CFG_INT_EN]);
  endproperty
  a_int_reset: assert property (p_int_reset) // RQ4
    else $error("interrupt output not released by reset");

  property p_rst_gate;
    @(posedge core_clk) disable iff (sys_rst)
      (rst_state == MAL_RST_IDLE && !cfg[CFG_RST_EN]) |=>
        reset_pin_oe_n;
  endproperty
  a_rst_gate: assert property (p_rst_gate) // RQ7
    else $error("reset pulse while its function is disabled");

  property p_ext_reset;
    @(posedge core_clk) disable iff (sys_rst)
      (rst_state == MAL_RST_IDLE && !reset_pin_in && clk_en) |=>
        ext_reset_seen;
  endproperty
  a_ext_reset: assert property (p_ext_reset) // RQ8
    else $error("low reset pin did not reset the device");

  property p_vid_read;
    @(posedge core_clk) disable iff (dev_rst)
      (reg_req.rd && clk_en && reg_req.addr == OFF_VID_HIGH) |=>
        (reg_rvalid && reg_rdata[0] == $past(vid_q[VID_W-1]));
  endproperty
  a_vid_read: assert property (p_vid_read) // RQ11
    else $error("high voltage-ID bit read back wrong");

endmodule

/* File: verification/mal_board_model.sv */
/*
  Board-side model for the monitor auxiliary pins: intrusion detector,
  reset network with pull-up, and processor voltage-ID drivers.
  Assumes open-drain enables from the design are active low.
*/
`timescale 1ns/1ps
module mal_board_model (
  input  wire logic       intruder_high,
  input  wire logic       board_rst_low,
  input  wire logic [4:0] cpu_vid,
  input  wire logic       cpu_vid_en,
  input  wire logic       intrusion_pin_oe_n,
  input  wire logic       reset_pin_oe_n,
  output logic            intrusion_pin_in,
  output logic            reset_pin_in,
  output logic [4:0]      voltage_id_inputs
);
  // ----------------------------------------------------------------
  // Wire resolution
  // ----------------------------------------------------------------
  // Detector drives high and wins over the clear pulse; it holds low
  // otherwise, so a released line never floats
  assign intrusion_pin_in = intruder_high;
  // Pull-up: low when either party pulls it
  assign reset_pin_in = ~(~reset_pin_oe_n | board_rst_low);
  // Released ID pins rise through their pull-ups
  assign voltage_id_inputs = cpu_vid_en ? cpu_vid : 5'h1f;
endmodule

/* File: verification/tb_top.sv */
/*
  Self-checking bench for the monitor auxiliary pin logic.
  Assumes the pulse length parameter is shortened to 16 cycles and
  that inputs change on the falling edge of the 40 MHz clock.
*/
`timescale 1ns/1ps
module tb_top;
  import mal_pkg::*;
  localparam int unsigned PL = 16;

  logic         core_clk, sys_rst, clk_en, int_req, alert_ack;
  logic         reset_trigger, dac_out_test_in;
  mal_reg_req_t reg_req;
  logic [7:0]   reg_rdata;
  logic         reg_rvalid, intrusion_pin_in, intrusion_pin_oe_n;
  logic         int_pin_oe_n, reset_pin_in, reset_pin_oe_n;
  logic         ext_reset_seen, tree_test_entry, ext_irq_active;
  logic         diode2_mode, intruder_high, board_rst_low, cpu_vid_en;
  logic [4:0]   cpu_vid, voltage_id_inputs;
  logic [7:0]   rd_val;
  int           err_total, checks_done, cnt;

  mal_aux_pins #(.PULSE_LEN(PL)) i_mal_aux_pins (
    .core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .intrusion_pin_in(intrusion_pin_in),
    .intrusion_pin_oe_n(intrusion_pin_oe_n), .int_req(int_req),
    .alert_ack(alert_ack), .int_pin_oe_n(int_pin_oe_n),
    .reset_trigger(reset_trigger), .reset_pin_in(reset_pin_in),
    .reset_pin_oe_n(reset_pin_oe_n), .ext_reset_seen(ext_reset_seen),
    .dac_out_test_in(dac_out_test_in), .tree_test_entry(tree_test_entry),
    .voltage_id_inputs(voltage_id_inputs),
    .ext_irq_active(ext_irq_active), .diode2_mode(diode2_mode));

  mal_board_model i_mal_board_model (
    .intruder_high(intruder_high), .board_rst_low(board_rst_low),
    .cpu_vid(cpu_vid), .cpu_vid_en(cpu_vid_en),
    .intrusion_pin_oe_n(intrusion_pin_oe_n),
    .reset_pin_oe_n(reset_pin_oe_n), .intrusion_pin_in(intrusion_pin_in),
    .reset_pin_in(reset_pin_in), .voltage_id_inputs(voltage_id_inputs));

  // ----------------------------------------------------------------
  // Clock and common tasks
  // ----------------------------------------------------------------
  // 25 ns period
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_byte({7'h0, got}, {7'h0, exp});
  endtask

  task automatic summarize;
    $display("checks=%0d errors=%0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // A bound that runs out ends the run at once
  task automatic give_up;
    err_total++;
    $display("[ERR] t=%0t got=%h exp=%h", $time, 8'hff, 8'h00);
    summarize();
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    reg_req.wr = 1'b1; reg_req.addr = a; reg_req.wdata = d;
    tick(1);
    reg_req.wr = 1'b0;
    tick(1);
  endtask

  // Holds the strobe over one taking edge, then waits for valid
  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
    int i;
    reg_req.rd = 1'b1; reg_req.addr = a;
    tick(1);
    reg_req.rd = 1'b0;
    for (i = 0; i < 4 && reg_rvalid !== 1'b1; i++) tick(1);
    if (reg_rvalid !== 1'b1) give_up();
    d = reg_rdata;
    tick(1);
  endtask

  // Picks the watched enable: 0 the intrusion pin, 1 the reset pin
  function automatic logic oe_sel(input logic sel);
    oe_sel = sel ? reset_pin_oe_n : intrusion_pin_oe_n;
  endfunction

  // Waits for an active-low enable to fall, then counts its low cycles
  task automatic low_len(input logic sel, output int n);
    int i;
    for (i = 0; i < 6 && oe_sel(sel) !== 1'b0; i++) tick(1);
    if (oe_sel(sel) !== 1'b0) give_up();
    n = 0;
    while (oe_sel(sel) === 1'b0 && n < 200) begin
      n++;
      tick(1);
    end
  endtask

  task automatic do_reset(input logic strap);
    sys_rst = 1'b1;
    dac_out_test_in = strap;
    tick(3);
    sys_rst = 1'b0;
    tick(3);
    dac_out_test_in = 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic sc_defaults;
    int_req = 1'b1;
    tick(3);
    chk_bit(int_pin_oe_n, 1'b1);
    reg_rd(OFF_CONFIG, rd_val);
    chk_byte(rd_val, 8'h00);
    chk_bit(tree_test_entry, 1'b0);
    int_req = 1'b0;
  endtask

  task automatic sc_intrusion;
    intruder_high = 1'b1;
    tick(3);
    intruder_high = 1'b0;
    tick(5);
    reg_rd(OFF_STATUS, rd_val);
    chk_byte(rd_val & 8'h01, 8'h01);
    tick(20);
    reg_rd(OFF_STATUS, rd_val);
    chk_byte(rd_val & 8'h01, 8'h01);
    reg_wr(OFF_INTR_CLEAR, 8'h80);
    low_len(1'b0, cnt);
    chk_byte(8'(cnt), 8'(PL));
    reg_rd(OFF_STATUS, rd_val);
    chk_byte(rd_val & 8'h01, 8'h00);
  endtask

  task automatic sc_interrupt;
    int_req = 1'b1;
    tick(3);
    chk_bit(int_pin_oe_n, 1'b1);
    reg_wr(OFF_CONFIG, 8'h02);
    tick(2);
    chk_bit(int_pin_oe_n, 1'b0);
    int_req = 1'b0;
    tick(2);
    chk_bit(int_pin_oe_n, 1'b1);
    reg_wr(OFF_CHAN_MODE, 8'h04);
    // Answer the alert left over from earlier requests first
    alert_ack = 1'b1;
    tick(1);
    alert_ack = 1'b0;
    tick(2);
    chk_bit(int_pin_oe_n, 1'b1);
    int_req = 1'b1;
    tick(1);
    int_req = 1'b0;
    tick(3);
    chk_bit(int_pin_oe_n, 1'b0);
    alert_ack = 1'b1;
    tick(1);
    alert_ack = 1'b0;
    tick(3);
    chk_bit(int_pin_oe_n, 1'b1);
  endtask

  task automatic sc_voltage_id;
    reg_wr(OFF_CHAN_MODE, 8'h01);
    cpu_vid = 5'h1e;
    cpu_vid_en = 1'b1;
    tick(3);
    chk_bit(ext_irq_active, 1'b1);
    chk_bit(int_pin_oe_n, 1'b0);
    cpu_vid = 5'h1f;
    tick(3);
    chk_bit(ext_irq_active, 1'b0);
    reg_wr(OFF_CHAN_MODE, 8'h00);
    cpu_vid = 5'h15;
    tick(3);
    chk_bit(ext_irq_active, 1'b0);
    reg_rd(OFF_VID_FAN, rd_val);
    chk_byte(rd_val & 8'h0f, 8'h05);
    reg_rd(OFF_VID_HIGH, rd_val);
    chk_byte(rd_val, 8'h01);
    cpu_vid_en = 1'b0;
  endtask

  task automatic sc_diode;
    reg_wr(OFF_CHAN_MODE, 8'h02);
    tick(1);
    chk_bit(diode2_mode, 1'b1);
    reg_wr(OFF_CHAN_MODE, 8'h00);
    tick(1);
    chk_bit(diode2_mode, 1'b0);
    // A write while the clock enable is low must be refused
    clk_en = 1'b0;
    reg_wr(OFF_CHAN_MODE, 8'h02);
    tick(1);
    chk_bit(diode2_mode, 1'b0);
    clk_en = 1'b1;
  endtask

  task automatic sc_master_reset;
    reset_trigger = 1'b1;
    tick(4);
    chk_bit(reset_pin_oe_n, 1'b1);
    reset_trigger = 1'b0;
    reg_wr(OFF_CONFIG, 8'h12);
    reset_trigger = 1'b1;
    tick(1);
    reset_trigger = 1'b0;
    low_len(1'b1, cnt);
    chk_bit(cnt >= PL, 1'b1);
    chk_bit(cnt <= PL + 2, 1'b1);
    tick(3);
    chk_bit(ext_reset_seen, 1'b0);
  endtask

  task automatic sc_ext_reset;
    board_rst_low = 1'b1;
    tick(3);
    chk_bit(ext_reset_seen, 1'b1);
    board_rst_low = 1'b0;
    tick(3);
    chk_bit(ext_reset_seen, 1'b0);
    reg_rd(OFF_CONFIG, rd_val);
    chk_byte(rd_val, 8'h00);
  endtask

  task automatic sc_tree;
    do_reset(1'b1);
    chk_bit(tree_test_entry, 1'b1);
    do_reset(1'b0);
    chk_bit(tree_test_entry, 1'b0);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    err_total = 0;
    checks_done = 0;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    int_req = 1'b0;
    alert_ack = 1'b0;
    reset_trigger = 1'b0;
    dac_out_test_in = 1'b0;
    reg_req = '0;
    intruder_high = 1'b0;
    board_rst_low = 1'b0;
    cpu_vid = 5'h1f;
    cpu_vid_en = 1'b0;
    do_reset(1'b0);
    sc_defaults();
    sc_intrusion();
    sc_interrupt();
    sc_voltage_id();
    sc_diode();
    sc_master_reset();
    sc_ext_reset();
    sc_tree();
    summarize();
  end
endmodule
